// *** disk_write_log_long_multiple_cmds_tb_top.sv ***
`default_nettype none
module disk_write_log_long_multiple_cmds_tb_top
  import dwl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk, i_nrst, i_go, i_lba_mode, i_mult_ready, i_wvalid;
  logic i_log_ok, i_log_ro, i_media_ack, i_media_err, err_on, m_chs;
  logic [7:0] i_op, i_blk_size, i_media_fail, o_log_sel, o_media_nsect;
  logic [15:0] i_cnt, i_feat, i_wdata, i_log_size, o_wdata;
  logic [47:0] i_lba, o_addr, o_media_addr, m_addr;
  logic o_wready, o_busy, o_done, o_err, o_abort;
  logic o_wvalid, o_wbyte, o_media_go, o_media_chs, o_media_log;
  int num_errors, cmp_count, cyc, n_go, n_int, n_word, n_byte, n_sec, m_dly;
  dwl_link_if dwl_link_if_i();
  dwl_host dwl_host_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_go(i_go),
    .i_op(i_op), .i_lba(i_lba), .i_cnt(i_cnt), .i_feat(i_feat),
    .i_lba_mode(i_lba_mode), .i_mult_ready(i_mult_ready),
    .i_wvalid(i_wvalid), .i_wdata(i_wdata), .o_wready(o_wready),
    .o_busy(o_busy), .o_done(o_done), .o_err(o_err), .o_abort(o_abort),
    .o_addr(o_addr), .link(dwl_link_if_i));
  dwl_dev dwl_dev_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_log_ok(i_log_ok), .i_log_ro(i_log_ro), .i_log_size(i_log_size),
    .o_log_sel(o_log_sel), .i_blk_size(i_blk_size), .o_wvalid(o_wvalid),
    .o_wbyte(o_wbyte), .o_wdata(o_wdata), .o_media_go(o_media_go),
    .o_media_addr(o_media_addr), .o_media_nsect(o_media_nsect),
    .o_media_chs(o_media_chs), .o_media_log(o_media_log),
    .i_media_ack(i_media_ack), .i_media_err(i_media_err),
    .i_media_fail(i_media_fail), .link(dwl_link_if_i));
  dwl_link_asserts dwl_link_asserts_i (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .tf_wr(dwl_link_if_i.tf_wr),
    .tf_sel(dwl_link_if_i.tf_sel), .tf_data(dwl_link_if_i.tf_data),
    .dat_valid(dwl_link_if_i.dat_valid), .dat_word(dwl_link_if_i.dat_word),
    .drq(dwl_link_if_i.drq), .dat_byte(dwl_link_if_i.dat_byte),
    .bsy(dwl_link_if_i.bsy), .intrq(dwl_link_if_i.intrq),
    .done(dwl_link_if_i.done), .err(dwl_link_if_i.err),
    .abrt(dwl_link_if_i.abrt), .rb_addr(dwl_link_if_i.rb_addr));
  // Clock generation
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  // Data source, media responder, monitors, hang guard
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    i_media_ack <= (m_dly == 1);
    if (o_wready && i_wvalid) i_wdata <= i_wdata + 16'h0001;
    if (dwl_link_if_i.intrq === 1'b1) n_int <= n_int + 1;
    if (o_wvalid === 1'b1 && o_wbyte === 1'b1) n_byte <= n_byte + 1;
    if (o_wvalid === 1'b1 && o_wbyte === 1'b0) n_word <= n_word + 1;
    if (o_media_go === 1'b1) begin
      n_go <= n_go + 1;
      n_sec <= n_sec + int'(o_media_nsect);
      if (n_go == 0) m_addr <= o_media_addr;
      if (n_go == 0) m_chs <= o_media_chs;
      m_dly <= 3;
    end else if (m_dly == 1) begin
      i_media_err <= err_on;
      m_dly <= 0;
    end else if (m_dly > 1) m_dly <= m_dly - 1;
    if (cyc == 60000) begin
      num_errors++;
      results();
    end
  end
  task automatic results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [47:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic ab(input string nm);
    chk(nm, 48'h1, 48'(o_abort));
    chk(nm, 48'h0, 48'(n_word));
  endtask : ab
  task automatic ok(input string nm, input logic [47:0] w);
    chk(nm, 48'h0, 48'(o_abort));
    chk(nm, w, 48'(n_word));
    chk(nm, 48'h0, 48'(o_busy));
  endtask : ok
  task automatic run(input logic [7:0] op, input logic [47:0] lba,
      input logic [15:0] cnt, f, input logic m);
    @(negedge i_sys_clk);
    n_go = 0; n_int = 0; n_word = 0; n_byte = 0; n_sec = 0;
    @(posedge i_sys_clk);
    i_op <= op; i_lba <= lba; i_cnt <= cnt; i_feat <= f; i_lba_mode <= m;
    i_go <= 1'b1;
    @(posedge i_sys_clk);
    i_go <= 1'b0;
    do @(negedge i_sys_clk); while (o_done !== 1'b1);
  endtask : run
  task automatic t_mult;
    @(posedge i_sys_clk);
    i_blk_size <= 8'h02;
    run(OP_MULT, 48'h0ABC0100, 16'h0005, 16'h0000, 1'b1);
    chk("blocks", 48'h3, 48'(n_go));
    chk("sectors", 48'h5, 48'(n_sec));
    chk("intrq", 48'h3, 48'(n_int));
    chk("words", 48'h500, 48'(n_word));
    chk("last addr", 48'h0ABC0104, o_addr);
  endtask : t_mult
  task automatic t_mult_err;
    @(posedge i_sys_clk);
    err_on <= 1'b1;
    i_media_fail <= 8'h01;
    run(OP_MULT, 48'h00000100, 16'h0004, 16'h0000, 1'b1);
    chk("err blocks", 48'h1, 48'(n_go));
    chk("err flag", 48'h1, 48'(o_err));
    chk("fail addr", 48'h00000101, o_addr);
    @(posedge i_sys_clk);
    err_on <= 1'b0;
  endtask : t_mult_err
  task automatic t_ext_chs;
    @(posedge i_sys_clk);
    i_blk_size <= 8'h04;
    run(OP_MULT_EXT, 48'h123456789ABC, 16'h0003, 16'h0000, 1'b1);
    chk("ext sectors", 48'h3, 48'(n_sec));
    chk("ext start", 48'h123456789ABC, m_addr);
    chk("ext last", 48'h123456789ABE, o_addr);
    run(OP_MULT_EXT, 48'h123456789ABC, 16'h0003, 16'h0000, 1'b0);
    ok("ext mode", 48'h300);
    run(OP_MULT, 48'h03001005, 16'h0001, 16'h0000, 1'b0);
    chk("chs flag", 48'h1, 48'(m_chs));
    chk("chs addr", 48'h00010305, m_addr);
  endtask : t_ext_chs
  task automatic t_long;
    run(OP_LONG_A, 48'h00001234, 16'h0001, 16'h0000, 1'b1);
    chk("long words", 48'h100, 48'(n_word));
    chk("long ecc", 48'h4, 48'(n_byte));
    chk("long blocks", 48'h1, 48'(n_go));
    run(OP_LONG_B, 48'h00001234, 16'h0001, 16'h0044, 1'b1);
    chk("long ext ecc", 48'h44, 48'(n_byte));
    run(OP_LONG_A, 48'h00001234, 16'h0002, 16'h0000, 1'b1);
    ok("long count", 48'h100);
  endtask : t_long
  task automatic t_log;
    run(OP_LOG_WR, 48'h000003A5, 16'h0002, 16'h0000, 1'b1);
    chk("log words", 48'h200, 48'(n_word));
    chk("log sel", 48'hA5, 48'(o_log_sel));
    chk("log start", 48'h000000A50003, m_addr);
    chk("log intrq", 48'h2, 48'(n_int));
    run(OP_LOG_WR, 48'h000003A5, 16'h0009, 16'h0000, 1'b1);
    ab("log size");
    run(OP_LOG_WR, 48'h000003A5, 16'h0002, 16'h0001, 1'b1);
    ab("log feat");
    @(posedge i_sys_clk);
    i_log_ro <= 1'b1;
    run(OP_LOG_WR, 48'h000003A5, 16'h0002, 16'h0000, 1'b1);
    ab("log ro");
    @(posedge i_sys_clk);
    i_log_ro <= 1'b0;
    i_log_ok <= 1'b0;
    run(OP_LOG_WR, 48'h000003A5, 16'h0002, 16'h0000, 1'b1);
    ab("log ok");
  endtask : t_log
  task automatic t_refuse;
    @(posedge i_sys_clk);
    i_mult_ready <= 1'b0;
    run(OP_MULT, 48'h00000100, 16'h0002, 16'h0000, 1'b1);
    ab("not ready");
    @(posedge i_sys_clk);
    i_mult_ready <= 1'b1;
    i_blk_size <= 8'h00;
    run(OP_MULT, 48'h00000100, 16'h0002, 16'h0000, 1'b1);
    ab("no block");
  endtask : t_refuse
  // Main sequence
  initial begin
    i_nrst = 1'b0; i_go = 1'b0; i_op = 8'h00; i_lba = 48'h0; i_cnt = 16'h0;
    i_feat = 16'h0; i_lba_mode = 1'b1; i_mult_ready = 1'b1; i_wvalid = 1'b1;
    i_wdata = 16'h0; i_log_ok = 1'b1; i_log_ro = 1'b0; i_log_size = 16'h0008;
    i_blk_size = 8'h02; i_media_ack = 1'b0; i_media_err = 1'b0;
    i_media_fail = 8'h00; err_on = 1'b0; m_chs = 1'b0; m_addr = 48'h0;
    num_errors = 0; cmp_count = 0; cyc = 0; m_dly = 0;
    repeat (20) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    t_mult();
    t_mult_err();
    t_ext_chs();
    t_long();
    t_log();
    t_refuse();
    results();
  end
endmodule : disk_write_log_long_multiple_cmds_tb_top
`default_nettype wire

// *** dwl_dev.sv ***
`default_nettype none
// What this block does
// RULE1 - Log write stores sectors into selected log
// RULE2 - Abort log write on bad log or fields
// RULE3 - Abort log write to read-only log
// RULE4 - Abort when 16-bit count exceeds log size
// RULE5 - Log start offset from mid-address bytes
// RULE6 - Long write takes host data and ECC
// RULE7 - Long write moves exactly one sector
// RULE8 - ECC bytes move byte-wide
// RULE9 - Four ECC bytes, sixty-eight when extended
// RULE10 - Bit 6 picks CHS or 28-bit LBA
// RULE11 - Multiple write interrupts per block
// RULE12 - Request gates only each block start
// RULE13 - Host sets block size before multiple write
// RULE14 - Whole blocks then partial remainder block
// RULE15 - Media error stops at failing sector
// RULE16 - Block-start interrupt except first block
// RULE17 - 48-bit address and count from pairs
// RULE18 - Registers show last or failing sector
// RULE19 - Each write shifts prior byte to previous
module dwl_dev
  import dwl_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Log directory lookup for o_log_sel
  input wire logic i_log_ok,
  input wire logic i_log_ro,
  input wire logic [15:0] i_log_size,
  output logic [7:0] o_log_sel,
  // Block size from multiple-mode setup
  input wire logic [7:0] i_blk_size,
  // Received data stream
  output logic o_wvalid,
  output logic o_wbyte,
  output logic [15:0] o_wdata,
  // Media write of one block
  output logic o_media_go,
  output logic [47:0] o_media_addr,
  output logic [7:0] o_media_nsect,
  output logic o_media_chs,
  output logic o_media_log,
  input wire logic i_media_ack,
  input wire logic i_media_err,
  input wire logic [7:0] i_media_fail,
  // Link to the host
  dwl_link_if.dev link
);
  dwl_dstate_t state_reg;
  logic [15:0] feat_reg;
  logic [15:0] cnt_reg;
  logic [15:0] lbal_reg;
  logic [15:0] lbam_reg;
  logic [15:0] lbah_reg;
  logic [7:0] dev_reg;
  logic [7:0] op_reg;
  logic [16:0] rem_reg;
  logic [7:0] blk_reg;
  logic [7:0] bsz_reg;
  logic [47:0] addr_reg;
  logic [7:0] word_reg;
  logic [7:0] sec_reg;
  logic [6:0] ecc_reg;
  logic [6:0] ecc_len_reg;
  logic drq_reg;
  logic byte_reg;
  logic bsy_reg;
  logic intrq_reg;
  logic done_reg;
  logic err_reg;
  logic abrt_reg;
  logic [47:0] rb_reg;
  logic cmd_go;
  logic take;
  logic is_log;
  logic is_long;
  logic is_mult;
  logic [27:0] addr28;
  logic [47:0] start_addr;
  logic [16:0] start_cnt;
  logic [16:0] start_bsz;
  logic abort_now;
  logic [16:0] rem_left;
  logic [7:0] blk_first;
  logic [7:0] blk_next;

  // Command and transfer qualifiers
  assign cmd_go = link.tf_wr && (link.tf_sel == TF_CMD) &&
                  (state_reg == DS_IDLE);
  // RULE12 words taken while request stands
  assign take = link.dat_valid && drq_reg;
  assign is_log = (op_reg == OP_LOG_WR);
  assign is_long = (op_reg == OP_LONG_A) || (op_reg == OP_LONG_B);
  assign is_mult = (op_reg == OP_MULT) || (op_reg == OP_MULT_EXT);

  // Task-file registers, writable while idle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      feat_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      lbal_reg <= 16'h0000;
      lbam_reg <= 16'h0000;
      lbah_reg <= 16'h0000;
      dev_reg <= 8'h00;
      op_reg <= 8'h00;
      o_log_sel <= 8'h00;
    end else if (link.tf_wr && state_reg == DS_IDLE) begin
      // RULE19 shift into previous slot
      unique case (link.tf_sel)
        TF_FEAT: feat_reg <= {feat_reg[7:0], link.tf_data};
        TF_CNT: cnt_reg <= {cnt_reg[7:0], link.tf_data};
        TF_LBAL: begin
          lbal_reg <= {lbal_reg[7:0], link.tf_data};
          o_log_sel <= link.tf_data;
        end
        TF_LBAM: lbam_reg <= {lbam_reg[7:0], link.tf_data};
        TF_LBAH: lbah_reg <= {lbah_reg[7:0], link.tf_data};
        TF_DEV: dev_reg <= link.tf_data;
        TF_CMD: op_reg <= link.tf_data;
        default: op_reg <= op_reg;
      endcase
    end
  end

  // Start address and count of the issued command
  always_comb begin
    // RULE10 CHS or LBA packing
    addr28 = dev_reg[DEV_LBA_BIT] ?
             {dev_reg[DEV_HEAD_MSB:0], lbah_reg[7:0], lbam_reg[7:0],
              lbal_reg[7:0]} :
             {lbah_reg[7:0], lbam_reg[7:0], dev_reg[DEV_HEAD_MSB:0],
              lbal_reg[7:0]};
    start_addr = {20'h00000, addr28};
    start_cnt = is_log ? {1'b0, cnt_reg} : {9'h000, cnt_reg[7:0]};
    start_bsz = 17'h00001;
    if (is_log) begin
      // RULE5 offset from mid pair
      start_addr = {24'h000000, lbal_reg[7:0], lbam_reg};
    end else if (op_reg == OP_MULT_EXT) begin
      // RULE17 48-bit address and count
      start_addr = {lbah_reg[15:8], lbam_reg[15:8], lbal_reg[15:8],
                    lbah_reg[7:0], lbam_reg[7:0], lbal_reg[7:0]};
      start_cnt = (cnt_reg == 16'h0000) ? CNT48_ZERO : {1'b0, cnt_reg};
    end else if (op_reg == OP_MULT) begin
      start_cnt = (cnt_reg[7:0] == 8'h00) ? CNT28_ZERO :
                  {9'h000, cnt_reg[7:0]};
    end
    // RULE11 block size from setup
    if (is_mult) begin
      start_bsz = {9'h000, i_blk_size};
    end
    blk_first = (start_cnt < start_bsz) ? start_cnt[7:0] :
                start_bsz[7:0];
  end

  // Validity checks at command start
  always_comb begin
    abort_now = !(is_log || is_long || is_mult);
    if (is_log) begin
      // RULE2 unsupported log or bad fields
      abort_now = !i_log_ok || (feat_reg != 16'h0000) ||
                  (lbah_reg != 16'h0000) || (lbal_reg[15:8] != 8'h00) ||
                  (cnt_reg == 16'h0000) || (lbam_reg >= i_log_size) ||
                  // RULE3 read-only log
                  i_log_ro ||
                  // RULE4 count beyond directory size
                  (cnt_reg > i_log_size);
    end else if (is_long) begin
      // RULE7 single sector only
      abort_now = (cnt_reg[7:0] != 8'h01);
    end else if (is_mult) begin
      abort_now = (i_blk_size == 8'h00) ||
                  ((op_reg == OP_MULT_EXT) && !dev_reg[DEV_LBA_BIT]);
    end
  end

  // Remaining count and next block length
  assign rem_left = rem_reg - {9'h000, blk_reg};
  // RULE14 partial final block
  assign blk_next = (rem_left < {9'h000, bsz_reg}) ? rem_left[7:0] :
                    bsz_reg;

  // Command sequencing, handshake and status
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= DS_IDLE;
      rem_reg <= 17'h00000;
      blk_reg <= 8'h00;
      bsz_reg <= 8'h00;
      addr_reg <= 48'h0;
      word_reg <= 8'h00;
      sec_reg <= 8'h00;
      ecc_reg <= 7'h00;
      ecc_len_reg <= ECC_LEN_STD;
      drq_reg <= 1'b0;
      byte_reg <= 1'b0;
      bsy_reg <= 1'b0;
      intrq_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      abrt_reg <= 1'b0;
      rb_reg <= 48'h0;
      o_media_go <= 1'b0;
      o_media_addr <= 48'h0;
      o_media_nsect <= 8'h00;
      o_media_chs <= 1'b0;
      o_media_log <= 1'b0;
    end else begin
      intrq_reg <= 1'b0;
      done_reg <= 1'b0;
      o_media_go <= 1'b0;
      unique case (state_reg)
        DS_IDLE: begin
          if (cmd_go) begin
            state_reg <= DS_CHECK;
            bsy_reg <= 1'b1;
            err_reg <= 1'b0;
            abrt_reg <= 1'b0;
          end
        end
        DS_CHECK: begin
          if (abort_now) begin
            state_reg <= DS_IDLE;
            bsy_reg <= 1'b0;
            done_reg <= 1'b1;
            intrq_reg <= 1'b1;
            err_reg <= 1'b1;
            abrt_reg <= 1'b1;
          end else begin
            // First block opens without an interrupt
            state_reg <= DS_DATA;
            drq_reg <= 1'b1;
            addr_reg <= start_addr;
            rem_reg <= start_cnt;
            bsz_reg <= start_bsz[7:0];
            blk_reg <= blk_first;
            word_reg <= 8'h00;
            sec_reg <= 8'h00;
            // RULE9 ECC length by features
            ecc_len_reg <= (feat_reg[7:0] == FEAT_ECC_EXT) ?
                           ECC_LEN_EXT : ECC_LEN_STD;
          end
        end
        DS_DATA: begin
          if (take) begin
            word_reg <= word_reg + 8'h01;
            if (word_reg == SEC_WORDS_M1) begin
              sec_reg <= sec_reg + 8'h01;
              if (sec_reg == blk_reg - 8'h01) begin
                if (is_long) begin
                  // RULE6 host supplies the ECC
                  state_reg <= DS_ECC;
                  byte_reg <= 1'b1;
                  ecc_reg <= 7'h00;
                end else begin
                  state_reg <= DS_MEDIA;
                  drq_reg <= 1'b0;
                  o_media_go <= 1'b1;
                end
              end
            end
          end
        end
        DS_ECC: begin
          // RULE8 one byte per take
          if (take) begin
            ecc_reg <= ecc_reg + 7'h01;
            if (ecc_reg == ecc_len_reg - 7'h01) begin
              state_reg <= DS_MEDIA;
              drq_reg <= 1'b0;
              byte_reg <= 1'b0;
              o_media_go <= 1'b1;
            end
          end
        end
        DS_MEDIA: begin
          if (i_media_ack) begin
            if (i_media_err) begin
              // RULE15 stop at failing sector
              rb_reg <= addr_reg + {40'h0, i_media_fail};
              err_reg <= 1'b1;
              state_reg <= DS_IDLE;
              bsy_reg <= 1'b0;
              done_reg <= 1'b1;
              intrq_reg <= 1'b1;
            end else begin
              // RULE18 last sector written
              rb_reg <= addr_reg + {40'h0, blk_reg} - 48'h1;
              addr_reg <= addr_reg + {40'h0, blk_reg};
              rem_reg <= rem_left;
              if (rem_left == 17'h00000) begin
                state_reg <= DS_IDLE;
                bsy_reg <= 1'b0;
                done_reg <= 1'b1;
                intrq_reg <= 1'b1;
              end else begin
                // RULE16 later block starts interrupt
                state_reg <= DS_DATA;
                drq_reg <= 1'b1;
                intrq_reg <= 1'b1;
                blk_reg <= blk_next;
                sec_reg <= 8'h00;
                word_reg <= 8'h00;
              end
            end
          end
        end
        default: state_reg <= DS_IDLE;
      endcase
      // Media request carries the block just received
      if (state_reg != DS_MEDIA) begin
        o_media_addr <= addr_reg;
        o_media_nsect <= blk_reg;
        o_media_chs <= !is_log && !dev_reg[DEV_LBA_BIT] &&
                       (op_reg != OP_MULT_EXT);
        // RULE1 stored in the selected log
        o_media_log <= is_log;
      end
    end
  end

  // Received words passed to the write path
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wvalid <= 1'b0;
      o_wbyte <= 1'b0;
      o_wdata <= 16'h0000;
    end else begin
      o_wvalid <= take;
      o_wbyte <= byte_reg;
      if (take) begin
        o_wdata <= byte_reg ? {8'h00, link.dat_word[7:0]} : link.dat_word;
      end
    end
  end

  // Link drive
  assign link.drq = drq_reg;
  assign link.dat_byte = byte_reg;
  assign link.bsy = bsy_reg;
  assign link.intrq = intrq_reg;
  assign link.done = done_reg;
  assign link.err = err_reg;
  assign link.abrt = abrt_reg;
  assign link.rb_addr = rb_reg;
endmodule : dwl_dev
`default_nettype wire

// *** dwl_host.sv ***
`default_nettype none
module dwl_host
  import dwl_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Command request
  input wire logic i_go,
  input wire logic [7:0] i_op,
  input wire logic [47:0] i_lba,
  input wire logic [15:0] i_cnt,
  input wire logic [15:0] i_feat,
  input wire logic i_lba_mode,
  input wire logic i_mult_ready,
  // Write data stream
  input wire logic i_wvalid,
  input wire logic [15:0] i_wdata,
  output logic o_wready,
  // Completion
  output logic o_busy,
  output logic o_done,
  output logic o_err,
  output logic o_abort,
  output logic [47:0] o_addr,
  // Link to the device
  dwl_link_if.host link
);
  dwl_hstate_t state_reg;
  logic [3:0] step_reg;
  logic ext_reg;
  logic [7:0] op_reg;
  logic [47:0] lba_reg;
  logic [15:0] cnt_reg;
  logic [15:0] feat_reg;
  logic [7:0] dev_reg;
  logic tf_wr_reg;
  logic [2:0] tf_sel_reg;
  logic [7:0] tf_data_reg;
  logic dat_valid_reg;
  logic dat_valid_next;
  logic [15:0] dat_word_reg;
  logic [15:0] step_val;
  logic load;
  logic taken;
  logic is_ext;
  logic is_mult;

  // Request decode
  assign is_ext = (i_op == OP_MULT_EXT) || (i_op == OP_LOG_WR);
  assign is_mult = (i_op == OP_MULT) || (i_op == OP_MULT_EXT);
  assign load = o_wready && i_wvalid;
  assign taken = dat_valid_reg && link.drq;
  assign dat_valid_next = load ? 1'b1 : (taken ? 1'b0 : dat_valid_reg);

  // Prev and current bytes of the register for this step
  always_comb begin
    unique case (step_reg[3:1])
      3'h0: step_val = feat_reg;
      3'h1: step_val = cnt_reg;
      3'h2: step_val = {lba_reg[31:24], lba_reg[7:0]};
      3'h3: step_val = {lba_reg[39:32], lba_reg[15:8]};
      default: step_val = {lba_reg[47:40], lba_reg[23:16]};
    endcase
  end

  // Command sequencing and completion
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= HS_IDLE;
      step_reg <= 4'h0;
      ext_reg <= 1'b0;
      op_reg <= 8'h00;
      lba_reg <= 48'h0;
      cnt_reg <= 16'h0000;
      feat_reg <= 16'h0000;
      dev_reg <= 8'h00;
      tf_wr_reg <= 1'b0;
      tf_sel_reg <= 3'h0;
      tf_data_reg <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_err <= 1'b0;
      o_abort <= 1'b0;
      o_addr <= 48'h0;
    end else begin
      tf_wr_reg <= 1'b0;
      o_done <= 1'b0;
      unique case (state_reg)
        HS_IDLE: begin
          // RULE13 setup first
          if (i_go && is_mult && !i_mult_ready) begin
            o_done <= 1'b1;
            o_err <= 1'b1;
            o_abort <= 1'b1;
          end else if (i_go) begin
            state_reg <= HS_REGS;
            o_busy <= 1'b1;
            o_err <= 1'b0;
            o_abort <= 1'b0;
            ext_reg <= is_ext;
            op_reg <= i_op;
            lba_reg <= i_lba;
            feat_reg <= i_feat;
            step_reg <= is_ext ? 4'h0 : 4'h1;
            // RULE7 long write count
            cnt_reg <= (i_op == OP_LONG_A || i_op == OP_LONG_B) ?
                       16'h0001 : i_cnt;
            // RULE17 host sets bit 6
            dev_reg <= {1'b0, i_lba_mode || i_op == OP_MULT_EXT, 2'h0,
                        is_ext ? 4'h0 : i_lba[27:24]};
          end
        end
        HS_REGS: begin
          tf_wr_reg <= 1'b1;
          if (step_reg == HSTEP_CMD) begin
            tf_sel_reg <= TF_CMD;
            tf_data_reg <= op_reg;
            state_reg <= HS_DATA;
          end else if (step_reg == HSTEP_DEV) begin
            tf_sel_reg <= TF_DEV;
            tf_data_reg <= dev_reg;
            step_reg <= HSTEP_CMD;
          end else begin
            // RULE19 high byte then low
            tf_sel_reg <= step_reg[3:1] + TF_FEAT;
            tf_data_reg <= step_reg[0] ? step_val[7:0] : step_val[15:8];
            step_reg <= (ext_reg || step_reg[0] == 1'b0 ||
                         step_reg == 4'h9) ? step_reg + 4'h1 :
                        step_reg + 4'h2;
          end
        end
        HS_DATA: begin
          if (link.done) begin
            state_reg <= HS_IDLE;
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_err <= link.err;
            o_abort <= link.abrt;
            o_addr <= link.rb_addr;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  // One-word hold stage towards the device
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dat_valid_reg <= 1'b0;
      dat_word_reg <= 16'h0000;
      o_wready <= 1'b0;
    end else if (state_reg != HS_DATA || link.done) begin
      dat_valid_reg <= 1'b0;
      o_wready <= (state_reg == HS_REGS) && (step_reg == HSTEP_CMD);
    end else begin
      dat_valid_reg <= dat_valid_next;
      o_wready <= !dat_valid_next;
      // RULE8 byte-wide ECC
      if (load) begin
        dat_word_reg <= link.dat_byte ? {8'h00, i_wdata[7:0]} : i_wdata;
      end
    end
  end

  // Link drive
  assign link.tf_wr = tf_wr_reg;
  assign link.tf_sel = tf_sel_reg;
  assign link.tf_data = tf_data_reg;
  assign link.dat_valid = dat_valid_reg;
  assign link.dat_word = dat_word_reg;
endmodule : dwl_host
`default_nettype wire

// *** dwl_link_asserts.sv ***
`default_nettype none
module dwl_link_asserts
  import dwl_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Host side of the link
  input wire logic tf_wr,
  input wire logic [2:0] tf_sel,
  input wire logic [7:0] tf_data,
  input wire logic dat_valid,
  input wire logic [15:0] dat_word,
  // Device side of the link
  input wire logic drq,
  input wire logic dat_byte,
  input wire logic bsy,
  input wire logic intrq,
  input wire logic done,
  input wire logic err,
  input wire logic abrt,
  input wire logic [47:0] rb_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  logic [6:0] ecc_cnt_reg;
  // Count ECC bytes taken within one command
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) ecc_cnt_reg <= 7'h00;
    else if (!bsy) ecc_cnt_reg <= 7'h00;
    else if (dat_byte && dat_valid && drq) ecc_cnt_reg <= ecc_cnt_reg + 7'h01;
  end
  // Command accepted, then first answer
  sequence s_cmd;
    tf_wr && tf_sel == TF_CMD && !bsy;
  endsequence
  sequence s_first;
    (drq && !intrq) || (done && abrt);
  endsequence
  a_cmd_sets_busy: assert property (s_cmd |=> bsy)
    else $error("busy not raised after command");
  a_first_block_quiet: assert property (s_cmd |-> ##2 s_first)
    else $error("first block answer wrong");
  a_abort_posts_err: assert property (done && abrt |-> err)
    else $error("abort without error flag");
  a_done_ends_busy: assert property (done |-> intrq ##1 !bsy)
    else $error("completion without interrupt or idle");
  a_block_intrq_drq: assert property (intrq && !done |-> ##[0:1] drq)
    else $error("block interrupt without request");
  a_drq_held: assert property ($fell(drq) |-> $past(dat_valid))
    else $error("request dropped without a take");
  a_byte_in_drq: assert property ($rose(dat_byte) |-> drq && bsy)
    else $error("byte phase outside request");
  a_ecc_len_ok: assert property ($fell(dat_byte) |->
      ecc_cnt_reg == ECC_LEN_STD || ecc_cnt_reg == ECC_LEN_EXT)
    else $error("ECC byte count wrong");
  a_drq_in_busy: assert property (drq |-> bsy)
    else $error("request while idle");
endmodule : dwl_link_asserts
`default_nettype wire

// *** dwl_link_if.sv ***
`default_nettype none
interface dwl_link_if;
  // Task-file write strobe from the host
  logic tf_wr;
  logic [2:0] tf_sel;
  logic [7:0] tf_data;
  // Host data word under the request handshake
  logic dat_valid;
  logic [15:0] dat_word;
  // Device status and readback
  logic drq;
  logic dat_byte;
  logic bsy;
  logic intrq;
  logic done;
  logic err;
  logic abrt;
  logic [47:0] rb_addr;
  modport dev (
    input tf_wr, tf_sel, tf_data, dat_valid, dat_word,
    output drq, dat_byte, bsy, intrq, done, err, abrt, rb_addr
  );
  modport host (
    output tf_wr, tf_sel, tf_data, dat_valid, dat_word,
    input drq, dat_byte, bsy, intrq, done, err, abrt, rb_addr
  );
endinterface : dwl_link_if
`default_nettype wire

// *** dwl_pkg.sv ***
`default_nettype none
package dwl_pkg;
  // Opcodes handled by this block
  localparam logic [7:0] OP_LOG_WR = 8'h3F;
  localparam logic [7:0] OP_LONG_A = 8'h32;
  localparam logic [7:0] OP_LONG_B = 8'h33;
  localparam logic [7:0] OP_MULT = 8'hC5;
  localparam logic [7:0] OP_MULT_EXT = 8'h39;
  // Features value selecting the extended ECC length
  localparam logic [7:0] FEAT_ECC_EXT = 8'h44;
  // ECC byte counts, default and extended
  localparam logic [6:0] ECC_LEN_STD = 7'h04;
  localparam logic [6:0] ECC_LEN_EXT = 7'h44;
  // Sector of 512 bytes is 256 data words
  localparam logic [7:0] SEC_WORDS_M1 = 8'hFF;
  // Task-file register selects
  localparam logic [2:0] TF_FEAT = 3'h1;
  localparam logic [2:0] TF_CNT = 3'h2;
  localparam logic [2:0] TF_LBAL = 3'h3;
  localparam logic [2:0] TF_LBAM = 3'h4;
  localparam logic [2:0] TF_LBAH = 3'h5;
  localparam logic [2:0] TF_DEV = 3'h6;
  localparam logic [2:0] TF_CMD = 3'h7;
  // Device register fields
  localparam int DEV_LBA_BIT = 6;
  localparam int DEV_HEAD_MSB = 3;
  // Zero counts stand for the largest count
  localparam logic [16:0] CNT28_ZERO = 17'h00100;
  localparam logic [16:0] CNT48_ZERO = 17'h10000;
  // Host register write sequence
  localparam logic [3:0] HSTEP_DEV = 4'hA;
  localparam logic [3:0] HSTEP_CMD = 4'hB;
  // Device and host states
  typedef enum logic [2:0] {
    DS_IDLE, DS_CHECK, DS_DATA, DS_ECC, DS_MEDIA
  } dwl_dstate_t;
  typedef enum logic [1:0] {
    HS_IDLE, HS_REGS, HS_DATA
  } dwl_hstate_t;
endpackage : dwl_pkg
`default_nettype wire
